// ===== verilog/fast_coding_regs.sv
/*
 * apb register bank for the fast coding sublayer: configuration bits,
 * receive error counter and interrupt status/mask.
 * assumes apb3 master on pclk; line events arrive asynchronously.
 */
`timescale 1ns/1ps
module fast_coding_regs
    import coding_regs_pkg::*;
#(
    parameter int SHORT_CYC = DESC_SHORT_CYC,
    parameter int LONG_CYC  = DESC_LONG_CYC
)
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // line events (asynchronous)
    input  wire logic        carrier_in,
    input  wire logic        symbol_err_in,
    input  wire logic        collision_in,
    // datapath controls
    output logic             quiet_transmit_enable,
    output logic             signal_detect_force,
    output logic             signal_detect_algorithm_select,
    output logic             descrambler_timeout_select,
    output logic             force_link_good,
    output logic             nrzi_bypass,
    output logic             descrambler_timeout,
    // interrupt
    output logic             irq
);
    logic [15:0]         config_reg;
    logic [15:0]         config_next;
    logic [7:0]          receive_error_count_reg;
    logic [7:0]          count_next;
    logic                counted_reg;
    logic                carrier_d_reg;
    logic [IRQ_BITS-1:0] status_reg;
    logic [IRQ_BITS-1:0] status_next;
    logic [IRQ_BITS-1:0] mask_reg;
    logic                carrier_s;
    logic                err_s;
    logic                coll_s;
    logic                tmo;

    // line inputs pass two flip-flops
    sync2 u_sync_car (.pclk(pclk), .presetn(presetn), .d(carrier_in), .q(carrier_s));
    sync2 u_sync_err (.pclk(pclk), .presetn(presetn), .d(symbol_err_in), .q(err_s));
    sync2 u_sync_col (.pclk(pclk), .presetn(presetn), .d(collision_in), .q(coll_s));

    // descrambler timer steered by the timeout select bit
    desc_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .long_sel (config_reg[BIT_DESC_LONG]),
        .activity (carrier_s),
        .timeout  (tmo)
    );

    // apb decode
    wire setup    = psel && !penable;
    wire access   = psel && penable;
    wire wr       = access && pwrite;
    // reads clear at the setup edge, where prdata is captured, so no event slips between
    wire rd       = setup && !pwrite;
    wire hit_cnt  = (paddr == OFF_RX_ERR_COUNT);
    wire hit_cfg  = (paddr == OFF_CONFIG);
    wire hit_sts  = (paddr == OFF_IRQ_STATUS);
    wire hit_msk  = (paddr == OFF_IRQ_MASK);
    wire mapped   = hit_cnt | hit_cfg | hit_sts | hit_msk;
    wire rd_cnt   = rd && hit_cnt;
    wire rd_sts   = rd && hit_sts;

    // only documented control bits are writable; 15:13 and reserved read zero
    assign config_next = (wr && hit_cfg) ? (pwdata[15:0] & CONFIG_WMASK) : config_reg;

    // error counting: one increment per carrier event, none during collision
    wire carrier_start = carrier_s && !carrier_d_reg;
    wire err_event     = carrier_s && err_s && !coll_s && !counted_reg;
    wire at_max        = (receive_error_count_reg == COUNT_MAX);
    wire inc           = err_event && !at_max;

    // a read clears, but an increment in the same cycle survives
    assign count_next = rd_cnt ? (err_event ? 8'h01 : 8'h00)
                               : (inc ? receive_error_count_reg + 8'h01 : receive_error_count_reg);

    // sticky events: set wins over read clear
    wire [IRQ_BITS-1:0] ev_set = {inc && (receive_error_count_reg == COUNT_MAX - 8'h01), inc};
    assign status_next = (rd_sts ? '0 : status_reg) | ev_set;

    // read mux
    wire [31:0] rdata_mux = hit_cnt ? {24'h000000, receive_error_count_reg}
                          : hit_cfg ? {16'h0000, config_reg}
                          : hit_sts ? {30'h0, status_reg}
                          : hit_msk ? {30'h0, mask_reg}
                          : 32'h00000000;

    // configuration register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            config_reg <= CONFIG_RESET;
        else
            config_reg <= config_next;
    end

    // error counter and per-carrier guard
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            receive_error_count_reg <= 8'h00;
            counted_reg             <= 1'b0;
            carrier_d_reg           <= 1'b0;
        end
        else
        begin
            receive_error_count_reg <= count_next;
            carrier_d_reg           <= carrier_s;
            if (err_event)
                counted_reg <= 1'b1;
            else if (!carrier_s)
                counted_reg <= 1'b0;
        end
    end

    // interrupt status and mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= '0;
            mask_reg   <= MASK_RESET;
        end
        else
        begin
            status_reg <= status_next;
            if (wr && hit_msk)
                mask_reg <= pwdata[IRQ_BITS-1:0];
        end
    end

    // bus answers: zero wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable) ? rdata_mux : prdata;
        end
    end

    // registered datapath controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quiet_transmit_enable          <= 1'b0;
            signal_detect_force            <= 1'b0;
            signal_detect_algorithm_select <= 1'b1;
            descrambler_timeout_select     <= 1'b0;
            force_link_good                <= 1'b0;
            nrzi_bypass                    <= 1'b0;
            descrambler_timeout            <= 1'b0;
            irq                            <= 1'b0;
        end
        else
        begin
            quiet_transmit_enable          <= config_next[BIT_QUIET_TX];
            signal_detect_force            <= config_next[BIT_SD_FORCE];
            signal_detect_algorithm_select <= config_next[BIT_SD_ALGO];
            descrambler_timeout_select     <= config_next[BIT_DESC_LONG];
            force_link_good                <= config_next[BIT_FORCE_LINK];
            nrzi_bypass                    <= config_next[BIT_NRZI_BYPASS];
            descrambler_timeout            <= tmo;
            irq                            <= |(status_next & mask_reg);
        end
    end

    // top bits never set
    a_top_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        config_reg[15:13] == 3'h0)
        else $error("config top bits not zero");

    // quiet transmit follows write one cycle later
    a_quiet_tx_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_cfg) |=> quiet_transmit_enable == $past(pwdata[BIT_QUIET_TX]))
        else $error("quiet transmit not updated");

    // signal detect force follows write
    a_sd_force_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_cfg) |=> signal_detect_force == $past(pwdata[BIT_SD_FORCE]))
        else $error("signal detect force not updated");

    // algorithm select output matches register
    a_sd_algo_match: assert property (@(posedge pclk) disable iff (!presetn)
        signal_detect_algorithm_select == config_reg[BIT_SD_ALGO])
        else $error("algorithm select mismatch");

    // timeout select and link force track writes
    a_desc_sel_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_cfg) |=> descrambler_timeout_select == $past(pwdata[BIT_DESC_LONG]))
        else $error("descrambler select not updated");

    a_force_link_match: assert property (@(posedge pclk) disable iff (!presetn)
        force_link_good == config_reg[BIT_FORCE_LINK])
        else $error("force link mismatch");

    a_nrzi_match: assert property (@(posedge pclk) disable iff (!presetn)
        nrzi_bypass == config_reg[BIT_NRZI_BYPASS])
        else $error("nrzi bypass mismatch");

    // counter saturates and never wraps to zero without a read
    a_count_sticks: assert property (@(posedge pclk) disable iff (!presetn)
        (at_max && !rd_cnt) |=> receive_error_count_reg == COUNT_MAX)
        else $error("error counter wrapped");

    // at most one increment per carrier event: the guard closes at once
    a_count_once: assert property (@(posedge pclk) disable iff (!presetn)
        inc |=> (counted_reg && !inc))
        else $error("counter incremented twice in one carrier");

    // a counter read clears it unless an error lands in the same cycle
    a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_cnt && !err_event) |=> receive_error_count_reg == 8'h00)
        else $error("counter not cleared by read");

    // without a read or an increment the counter holds
    a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!rd_cnt && !inc) |=> $stable(receive_error_count_reg))
        else $error("counter changed without cause");

    // an event in the cycle of a status read survives the clear
    a_status_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_sts && ev_set[0]) |=> status_reg[0])
        else $error("status event lost to read clear");

    // interrupt is the registered or of the unmasked status bits
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(mask_reg) |-> irq == |(status_reg & mask_reg))
        else $error("irq level wrong");

    // every setup cycle is answered in the next cycle
    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("no ready after setup");

    // ready stands for one cycle only
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready longer than one cycle");

    // an error answer always comes with ready
    a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("slave error without ready");

    // read data holds until the next setup cycle
    a_read_stands: assert property (@(posedge pclk) disable iff (!presetn)
        !setup |=> $stable(prdata))
        else $error("read data changed outside setup");

    // a write to an unmapped address changes nothing
    a_unmapped_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !mapped) |=> ($stable(config_reg) && $stable(mask_reg)))
        else $error("unmapped write took effect");

    // a config write keeps only the documented control bits
    a_cfg_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_cfg) |=> config_reg == ($past(pwdata[15:0]) & CONFIG_WMASK))
        else $error("config write not masked");

    // reserved and top bits stay clear
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (config_reg & ~CONFIG_WMASK) == 16'h0000)
        else $error("reserved config bit set");

    // carrier clears the descrambler timeout two cycles on
    a_timeout_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        carrier_s |-> ##2 !descrambler_timeout)
        else $error("timeout not cleared by carrier");
endmodule : fast_coding_regs

// ===== verilog/coding_regs_pkg.sv
/*
 * constants for the fast coding sublayer configuration block:
 * register offsets, field positions, reset values and timing counts.
 * assumes a 200 mhz pclk and an apb slave with 32-bit data.
 */
package coding_regs_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_RX_ERR_COUNT = 12'h054; // index 0x15
    localparam logic [11:0] OFF_CONFIG       = 12'h058; // index 0x16
    localparam logic [11:0] OFF_IRQ_STATUS   = 12'h060;
    localparam logic [11:0] OFF_IRQ_MASK     = 12'h064;
    localparam int          REG_INDEX_RX_ERR = 'h15;
    localparam int          REG_INDEX_CONFIG = 'h16;
    // configuration field positions
    localparam int BIT_QUIET_TX    = 10;
    localparam int BIT_SD_FORCE    = 9;
    localparam int BIT_SD_ALGO     = 8;
    localparam int BIT_DESC_LONG   = 7;
    localparam int BIT_FORCE_LINK  = 5;
    localparam int BIT_NRZI_BYPASS = 2;
    // writable bits of the configuration register
    localparam logic [15:0] CONFIG_WMASK = 16'h07a4;
    localparam logic [15:0] CONFIG_RESET = 16'h0100;
    // interrupt events: 0 counter incremented, 1 counter saturated
    localparam int          IRQ_BITS   = 2;
    localparam logic [1:0]  MASK_RESET = 2'h0;
    localparam logic [7:0]  COUNT_MAX  = 8'hff;
    // descrambler timeouts
    localparam int CLK_MHZ         = 200;
    localparam int DESC_SHORT_US   = 722;
    localparam int DESC_LONG_US    = 2000;
    localparam int DESC_SHORT_CYC  = DESC_SHORT_US * CLK_MHZ;
    localparam int DESC_LONG_CYC   = DESC_LONG_US * CLK_MHZ;
endpackage : coding_regs_pkg

// ===== verilog/sync2.sv
/*
 * two flip-flop synchroniser for one level.
 * assumes the input is asynchronous to pclk.
 */
`timescale 1ns/1ps
module sync2
    import coding_regs_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // data
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : sync2

// ===== verilog/desc_timer.sv
/*
 * descrambler lock timer: counts idle cycles since last activity and
 * flags a timeout at the selected limit.
 * assumes activity is synchronous to pclk.
 */
`timescale 1ns/1ps
module desc_timer
    import coding_regs_pkg::*;
#(
    parameter int SHORT_CYC = DESC_SHORT_CYC,
    parameter int LONG_CYC  = DESC_LONG_CYC
)
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic long_sel,
    input  wire logic activity,
    // status
    output logic      timeout
);
    logic [19:0] count_reg;
    logic [19:0] count_next;
    wire  [19:0] limit = long_sel ? 20'(LONG_CYC) : 20'(SHORT_CYC);
    wire         hit   = (count_reg >= limit);

    assign count_next = activity ? 20'h00000 : (hit ? count_reg : count_reg + 20'h00001);

    // idle counter and timeout flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_reg <= 20'h00000;
            timeout   <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            timeout   <= hit && !activity;
        end
    end
endmodule : desc_timer

// ===== tb/pcs_fast_config_register_tb_top.sv
/*
 * self-checking bench for the fast coding register bank: apb master tasks,
 * line event stimulus and an integer model of counter, status and config.
 * assumes the design answers apb requests and syncs line inputs itself.
 */
`timescale 1ns/1ps
module pcs_fast_config_register_tb_top;
    import coding_regs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        carrier_in, symbol_err_in, collision_in, err, dtmo;
    logic [5:0]  cfg_out;
    int          miscompares, n_checks, exp_cnt, exp_st, i;
    logic [15:0] exp_cfg, wv;

    // design with short descrambler limits
    fast_coding_regs #(.SHORT_CYC(20), .LONG_CYC(50)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .carrier_in(carrier_in), .symbol_err_in(symbol_err_in),
        .collision_in(collision_in), .quiet_transmit_enable(cfg_out[5]),
        .signal_detect_force(cfg_out[4]), .signal_detect_algorithm_select(cfg_out[3]),
        .descrambler_timeout_select(cfg_out[2]), .force_link_good(cfg_out[1]),
        .nrzi_bypass(cfg_out[0]), .descrambler_timeout(dtmo), .irq(irq));

    // 200 mhz clock
    always #2.5 pclk = ~pclk;

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; waits for pready under a bound
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                miscompares++;
                wrap_up();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // config readback and the six control outputs
    task chk_cfg;
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(rd, {16'h0, exp_cfg}, "config read");
        chk({26'h0, cfg_out}, {26'h0, exp_cfg[10:7], exp_cfg[5], exp_cfg[2]}, "ctl");
    endtask : chk_cfg

    // one carrier event with nerr symbol errors; model counts once per carrier
    task carrier_ev(input int nerr, input logic coll);
        carrier_in <= 1'b1;
        collision_in <= coll;
        repeat (4) @(posedge pclk);
        repeat (nerr)
        begin
            symbol_err_in <= 1'b1;
            repeat (3) @(posedge pclk);
            symbol_err_in <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        carrier_in <= 1'b0;
        collision_in <= 1'b0;
        repeat (6) @(posedge pclk);
        if (nerr > 0 && !coll && exp_cnt < 255)
        begin
            exp_cnt++;
            exp_st |= 1;
            if (exp_cnt == 255)
                exp_st |= 2;
        end
    endtask : carrier_ev

    // main sequence
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; carrier_in = 0; symbol_err_in = 0; collision_in = 0;
        miscompares = 0; n_checks = 0; exp_cnt = 0; exp_st = 0;
        exp_cfg = CONFIG_RESET;
        void'($urandom(64));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk_cfg();
        $display("test reset done");
        // all ones, zeros and random writes, reserved bits dropped
        for (i = 0; i < 8; i++)
        begin
            wv = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            wv = wv & (CONFIG_WMASK | 16'he000); // top bits kept to prove they are ignored
            apb(1'b1, OFF_CONFIG, {16'hffff, wv});
            chk({31'h0, err}, 32'h0, "cfg slverr");
            exp_cfg = wv & CONFIG_WMASK;
            chk_cfg();
        end
        // each low control alone, then a reset in mid-run
        exp_cfg = 16'(1 << BIT_DESC_LONG);
        apb(1'b1, OFF_CONFIG, {16'h0, exp_cfg});
        chk_cfg();
        exp_cfg = 16'(1 << BIT_FORCE_LINK);
        apb(1'b1, OFF_CONFIG, {16'h0, exp_cfg});
        chk_cfg();
        exp_cfg = 16'(1 << BIT_NRZI_BYPASS);
        apb(1'b1, OFF_CONFIG, {16'h0, exp_cfg});
        chk_cfg();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        exp_cfg = CONFIG_RESET;
        chk_cfg();
        $display("test config done");
        // unmapped place refused
        apb(1'b1, 12'h0f0, 32'h1234);
        chk({31'h0, err}, 32'h1, "unmapped err");
        apb(1'b0, 12'h0f0, 32'h0);
        chk(rd, 32'h0, "unmapped data");
        // counter, status and irq with random error bursts
        apb(1'b1, OFF_IRQ_MASK, 32'h3);
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk(rd, 32'h3, "mask");
        for (i = 0; i < 6; i++)
        begin
            carrier_ev(int'($urandom % 4), i == 3);
            chk({31'h0, irq}, {31'h0, exp_st != 0}, "irq");
            apb(1'b0, OFF_RX_ERR_COUNT, 32'h0);
            chk(rd, exp_cnt, "count");
            exp_cnt = 0;
            apb(1'b0, OFF_IRQ_STATUS, 32'h0);
            chk(rd, exp_st, "status");
            exp_st = 0;
            chk({31'h0, irq}, 32'h0, "irq clear");
        end
        apb(1'b1, OFF_IRQ_MASK, 32'h0);
        for (i = 0; i < 258; i++)
            carrier_ev(1, 1'b0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b0, OFF_RX_ERR_COUNT, 32'h0);
        chk(rd, 32'hff, "saturated");
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h3, "sat status");
        exp_cnt = 0;
        exp_st = 0;
        $display("test counter done");
        // descrambler timeout, short then long limit
        apb(1'b1, OFF_CONFIG, 32'h0);
        carrier_ev(0, 1'b0);
        chk({31'h0, dtmo}, 32'h0, "tmo early");
        repeat (30) @(posedge pclk);
        chk({31'h0, dtmo}, 32'h1, "tmo short");
        apb(1'b0, OFF_CONFIG, 32'h0);
        apb(1'b1, OFF_CONFIG, (rd & 32'(CONFIG_WMASK)) | 32'(1 << BIT_DESC_LONG));
        carrier_ev(0, 1'b0);
        repeat (30) @(posedge pclk);
        chk({31'h0, dtmo}, 32'h0, "tmo long early");
        repeat (40) @(posedge pclk);
        chk({31'h0, dtmo}, 32'h1, "tmo long");
        $display("test timeout done");
        wrap_up();
    end
endmodule : pcs_fast_config_register_tb_top
